// ---- core/cbrd_pkg.sv ----
// Constants shared by the processor-board refresh and decode glue
package cbrd_pkg;
   // Master clock period
   localparam int unsigned CLK_NS = 50;
   // Processor cycle, two phases inside it
   localparam int unsigned CPU_CYCLE_NS = 1500;
   localparam int unsigned CPU_CYCLE_CYC = CPU_CYCLE_NS / CLK_NS;
   localparam logic [4:0] PHASE_LAST = 5'(CPU_CYCLE_CYC - 1);
   localparam logic [4:0] PH1_START = 5'h00;
   localparam logic [4:0] PH1_STOP = 5'h0d;
   localparam logic [4:0] PH2_START = 5'h0e;
   localparam logic [4:0] PH2_STOP = 5'h1d;
   // Refresh period
   localparam int unsigned REFRESH_US = 2000;
   localparam int unsigned REFRESH_CYC = REFRESH_US * 1000 / CLK_NS;
   // Least gap from cycle strobe to write strobe, rounded up
   localparam int unsigned WE_DELAY_NS = 200;
   localparam int unsigned WE_DELAY_CYC = (WE_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] WE_DELAY = 3'(WE_DELAY_CYC);
   // Refresh rows and the wait for bus release before forcing
   localparam logic [5:0] ROW_LAST = 6'h3f;
   localparam logic [4:0] STUCK_PH1 = 5'h10;
   // Address map
   localparam logic [15:0] RAM_TOP = 16'h0fff;
   localparam logic [15:0] EPROM_BASE = 16'hfc00;
   localparam logic [15:0] ADAPTER_BASE = 16'hf040;
   localparam logic [15:0] ADAPTER_TOP = 16'hf043;
   localparam logic [15:0] RTC_CLEAR = 16'hf044;
   // Real-time divider default tap
   localparam int unsigned RTC_TAP_DEF = 4;
   // Refresh sequencer states
   typedef enum logic [2:0] {
      CBRD_IDLE = 3'b001,
      CBRD_WAIT = 3'b010,
      CBRD_COUNT = 3'b100
   } cbrd_state_t;
endpackage

// ---- core/cbrd_top.sv ----
// Clock phases, DRAM refresh, address decode and real-time divider
//
// Overview of operation
// RULE_01: Two non-overlapping phases, 1.50 us cycle.
// RULE_02: Start whole-RAM refresh every 2 ms.
// RULE_03: Refresh raises active, enables counter, halts CPU.
// RULE_04: Bus release disables CPU addresses, gates counting.
// RULE_05: Counter steps once per phase one, drives rows.
// RULE_06: At count 64 clear refresh, halt, counter.
// RULE_07: Refresh proceeds even without bus release.
// RULE_08: Data buffers point to CPU when read.
// RULE_09: Addresses 0000-0FFF assert RAM select and strobe.
// RULE_10: Cycle strobe also asserted during refresh.
// RULE_11: Write strobe at least 200 ns after cycle strobe.
// RULE_12: RAM read buffers enabled on reads only.
// RULE_13: Top 1K selects one of four EPROMs.
// RULE_14: F040-F043 select the peripheral adapter.
// RULE_15: Divider counts refreshes, interrupts at chosen tap.
// RULE_16: Address F044 clears the divider.
// RULE_17: System reset clears the divider.
// RULE_18: Interrupt drives adapter control input one.
// RULE_19: Adapter port A read clears the interrupt.
// RULE_20: Six-bit row counter restarts at zero.
// RULE_21: Divider tap is a build parameter.
`timescale 1ns/1ps
`default_nettype none
module cbrd_top #(
   parameter int unsigned REFRESH_CYCLES = cbrd_pkg::REFRESH_CYC,
   parameter int unsigned RTC_TAP = cbrd_pkg::RTC_TAP_DEF
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Processor bus
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rw,
   input wire logic cpu_vma,
   input wire logic bus_released,
   // Processor clocks and control
   output logic ph1,
   output logic ph2,
   output logic halt_req,
   output logic cpu_addr_buf_en,
   output logic data_to_cpu,
   // Refresh address drive
   output logic refresh_active,
   output logic row_drive_en,
   output logic [5:0] refresh_row,
   // Dynamic RAM
   output logic ram_sel,
   output logic ram_cycle,
   output logic ram_we,
   output logic ram_rdbuf_en,
   // EPROM and adapter
   output logic [3:0] eprom_sel,
   output logic [7:0] eprom_word,
   output logic peripheral_adapter_cs,
   output logic adapter_control_input_one
);
   localparam int TW = $clog2(REFRESH_CYCLES + 1);

   logic [4:0] phase;
   logic ph1_pulse;
   logic [TW-1:0] ref_timer;
   logic refresh_tick;
   cbrd_pkg::cbrd_state_t state;
   logic [4:0] stuck_cnt;
   logic [2:0] ce_age;
   logic [RTC_TAP-1:0] rt_count;
   logic in_ram, in_eprom, in_adapter, rtc_hit, porta_read;

   ////////////////////////////////////////////////////////////////////
   // Two-phase clock: gaps at both ends keep the phases apart
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phase <= 5'h00;
         ph1 <= 1'b0;
         ph2 <= 1'b0;
         ph1_pulse <= 1'b0;
      end else begin
         phase <= (phase == cbrd_pkg::PHASE_LAST) ? 5'h00 : phase + 5'h01;
         ph1 <= (phase < cbrd_pkg::PH1_STOP); // RULE_01
         ph2 <= (phase >= cbrd_pkg::PH2_START) &&
                (phase < cbrd_pkg::PH2_STOP); // RULE_01
         ph1_pulse <= (phase == cbrd_pkg::PH1_START);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Free-running refresh timer
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_timer <= '0;
         refresh_tick <= 1'b0;
      end else begin
         refresh_tick <= (ref_timer == TW'(REFRESH_CYCLES - 1)); // RULE_02
         if (ref_timer == TW'(REFRESH_CYCLES - 1)) begin
            ref_timer <= '0;
         end else begin
            ref_timer <= ref_timer + TW'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Refresh sequencer; a tick during a refresh is dropped since the
   // running pass already covers every row
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= cbrd_pkg::CBRD_IDLE;
         refresh_active <= 1'b0;
         refresh_row <= 6'h00;
         stuck_cnt <= 5'h00;
      end else begin
         case (state)
            cbrd_pkg::CBRD_IDLE: begin
               if (refresh_tick) begin
                  state <= cbrd_pkg::CBRD_WAIT;
                  refresh_active <= 1'b1; // RULE_03
                  refresh_row <= 6'h00; // RULE_20
                  stuck_cnt <= 5'h00;
               end
            end
            cbrd_pkg::CBRD_WAIT: begin
               if (ph1_pulse) begin
                  // A hung processor never releases; force after a wait
                  if (bus_released || stuck_cnt == cbrd_pkg::STUCK_PH1) begin
                     state <= cbrd_pkg::CBRD_COUNT; // RULE_04 RULE_07
                  end else begin
                     stuck_cnt <= stuck_cnt + 5'h01; // RULE_07
                  end
               end
            end
            cbrd_pkg::CBRD_COUNT: begin
               if (ph1_pulse) begin
                  if (refresh_row == cbrd_pkg::ROW_LAST) begin
                     state <= cbrd_pkg::CBRD_IDLE; // RULE_06
                     refresh_active <= 1'b0; // RULE_06
                     refresh_row <= 6'h00; // RULE_06
                  end else begin
                     refresh_row <= refresh_row + 6'h01; // RULE_05
                  end
               end
            end
            default: begin
               state <= cbrd_pkg::CBRD_IDLE;
               refresh_active <= 1'b0;
               refresh_row <= 6'h00;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Halt, address drivers and processor buffer control
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         halt_req <= 1'b0;
         row_drive_en <= 1'b0;
         cpu_addr_buf_en <= 1'b1;
         data_to_cpu <= 1'b1;
      end else begin
         halt_req <= (state == cbrd_pkg::CBRD_IDLE) ? refresh_tick :
                     !(state == cbrd_pkg::CBRD_COUNT && ph1_pulse &&
                       refresh_row == cbrd_pkg::ROW_LAST); // RULE_03
         row_drive_en <= (state == cbrd_pkg::CBRD_IDLE) ? refresh_tick :
                         !(state == cbrd_pkg::CBRD_COUNT && ph1_pulse &&
                           refresh_row == cbrd_pkg::ROW_LAST); // RULE_03
         cpu_addr_buf_en <= !bus_released; // RULE_04
         data_to_cpu <= cpu_rw; // RULE_08
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address decode terms
   assign in_ram = cpu_vma && !refresh_active &&
                   (cpu_addr <= cbrd_pkg::RAM_TOP);
   assign in_eprom = cpu_vma && (cpu_addr >= cbrd_pkg::EPROM_BASE);
   assign in_adapter = cpu_vma && (cpu_addr >= cbrd_pkg::ADAPTER_BASE) &&
                       (cpu_addr <= cbrd_pkg::ADAPTER_TOP);
   assign rtc_hit = cpu_vma && (cpu_addr == cbrd_pkg::RTC_CLEAR);
   assign porta_read = cpu_vma && cpu_rw &&
                       (cpu_addr == cbrd_pkg::ADAPTER_BASE);

   ////////////////////////////////////////////////////////////////////
   // RAM select, cycle strobe and read buffers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ram_sel <= 1'b0;
         ram_cycle <= 1'b0;
         ram_rdbuf_en <= 1'b0;
      end else begin
         ram_sel <= in_ram; // RULE_09
         ram_cycle <= in_ram || refresh_active; // RULE_09 RULE_10
         ram_rdbuf_en <= in_ram && cpu_rw; // RULE_12
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write strobe held off until the cycle strobe has aged enough
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ce_age <= 3'h0;
         ram_we <= 1'b0;
      end else begin
         if (!ram_cycle) begin
            ce_age <= 3'h0;
         end else if (ce_age != 3'h7) begin
            ce_age <= ce_age + 3'h1;
         end
         ram_we <= ram_sel && in_ram && !cpu_rw && ph2 &&
                   (ce_age >= cbrd_pkg::WE_DELAY); // RULE_11
      end
   end

   ////////////////////////////////////////////////////////////////////
   // EPROM and adapter selects
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         eprom_sel <= 4'h0;
         eprom_word <= 8'h00;
         peripheral_adapter_cs <= 1'b0;
      end else begin
         eprom_sel <= in_eprom ? (4'h1 << cpu_addr[9:8]) : 4'h0; // RULE_13
         eprom_word <= cpu_addr[7:0]; // RULE_13
         peripheral_adapter_cs <= in_adapter; // RULE_14
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Real-time divider; the tap is strapped, so a parameter, not software
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rt_count <= '0; // RULE_17
      end else if (rtc_hit) begin
         rt_count <= '0; // RULE_16
      end else if (refresh_tick) begin
         rt_count <= rt_count + RTC_TAP'(1); // RULE_15 RULE_21
      end
   end

   // Interrupt flag: a carry out of the tap beats a same-cycle clear
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         adapter_control_input_one <= 1'b0; // RULE_17
      end else if (refresh_tick && (&rt_count)) begin
         adapter_control_input_one <= 1'b1; // RULE_15 RULE_18
      end else if (rtc_hit || porta_read) begin
         adapter_control_input_one <= 1'b0; // RULE_16 RULE_19
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_ph1_fall;
      ph1 ##1 !ph1;
   endsequence
   sequence s_refresh_start;
      state == cbrd_pkg::CBRD_IDLE && refresh_tick;
   endsequence
   sequence s_last_row;
      state == cbrd_pkg::CBRD_COUNT && ph1_pulse &&
      refresh_row == cbrd_pkg::ROW_LAST;
   endsequence

   property p_no_overlap;
      $rose(ph2) |-> !ph1 && !$past(ph1);
   endproperty
   a_no_overlap: assert property (p_no_overlap) // RULE_01
      else $error("phases overlap");

   // The one dead cycle must also sit before phase one rises
   property p_ph1_gap;
      $rose(ph1) |-> !ph2 && !$past(ph2);
   endproperty
   a_ph1_gap: assert property (p_ph1_gap) // RULE_01
      else $error("phase one rose too soon");

   property p_cycle;
      s_ph1_fall |-> ##30 (!ph1 && $past(ph1));
   endproperty
   a_cycle: assert property (p_cycle) // RULE_01
      else $error("cycle length wrong");

   property p_start;
      s_refresh_start |=> refresh_active && halt_req && row_drive_en &&
                          refresh_row == 6'h00;
   endproperty
   a_start: assert property (p_start) // RULE_03
      else $error("refresh start missed");

   property p_step;
      state == cbrd_pkg::CBRD_COUNT && ph1_pulse &&
      refresh_row != cbrd_pkg::ROW_LAST |=>
         refresh_row == $past(refresh_row) + 6'h01;
   endproperty
   a_step: assert property (p_step) // RULE_05
      else $error("row did not step");

   property p_end;
      s_last_row |=> !refresh_active && !halt_req && refresh_row == 6'h00;
   endproperty
   a_end: assert property (p_end) // RULE_06
      else $error("refresh not ended");

   property p_stuck;
      state == cbrd_pkg::CBRD_WAIT |-> stuck_cnt <= cbrd_pkg::STUCK_PH1;
   endproperty
   a_stuck: assert property (p_stuck) // RULE_07
      else $error("forced refresh late");

   property p_ram;
      in_ram |=> ram_sel && ram_cycle && (ram_rdbuf_en == data_to_cpu);
   endproperty
   a_ram: assert property (p_ram) // RULE_09
      else $error("RAM decode wrong");

   property p_ce_refresh;
      refresh_active |=> ram_cycle;
   endproperty
   a_ce_refresh: assert property (p_ce_refresh) // RULE_10
      else $error("no refresh CE");

   property p_we_gap;
      ram_we |-> ram_cycle && $past(ram_cycle, 4);
   endproperty
   a_we_gap: assert property (p_we_gap) // RULE_11
      else $error("write strobe early");

   property p_rdbuf;
      ram_rdbuf_en |-> ram_sel && data_to_cpu;
   endproperty
   a_rdbuf: assert property (p_rdbuf) // RULE_12
      else $error("read buffer on write");

   property p_eprom;
      in_eprom |=> eprom_sel == (4'h1 << $past(cpu_addr[9:8]));
   endproperty
   a_eprom: assert property (p_eprom) // RULE_13
      else $error("EPROM select wrong");

   property p_adapter;
      in_adapter |=> peripheral_adapter_cs;
   endproperty
   a_adapter: assert property (p_adapter) // RULE_14
      else $error("adapter select");

   property p_rtc_clear;
      rtc_hit && !refresh_tick |=>
         rt_count == '0 && !adapter_control_input_one;
   endproperty
   a_rtc_clear: assert property (p_rtc_clear) // RULE_16
      else $error("divider kept");

   property p_porta;
      porta_read && !refresh_tick |=> !adapter_control_input_one;
   endproperty
   a_porta: assert property (p_porta) // RULE_19
      else $error("port A read no clear");
endmodule // cbrd_top
`default_nettype wire

// ---- verif/cbrd_cpu_model.sv ----
// Processor-side model: answers a halt request with bus release
`timescale 1ns/1ps
`default_nettype none
module cbrd_cpu_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Halt handshake
   input wire logic halt_req,
   input wire logic [1:0] release_mode,
   output logic bus_released
);
   int wait_cnt;

   ////////////////////////////////////////////////////////////////////
   // Mode 0 ends its instruction fast, mode 1 slowly, mode 2 hangs;
   // release drops as soon as the halt request goes away
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_cnt <= 0;
         bus_released <= 1'b0;
      end else if (!halt_req) begin
         wait_cnt <= 0;
         bus_released <= 1'b0;
      end else begin
         wait_cnt <= wait_cnt + 1;
         bus_released <= (release_mode == 2'h0 && wait_cnt >= 2) ||
            (release_mode == 2'h1 && wait_cnt >= 200);
      end
   end
endmodule // cbrd_cpu_model
`default_nettype wire

// ---- verif/tb_cpu_board_refresh_decode.sv ----
// Self-checking testbench for the refresh and decode glue
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_board_refresh_decode;
   localparam int unsigned REF_CYC = 3000;
   localparam int unsigned TAP = 2;
   logic mclk, sys_rst, cpu_rw, cpu_vma, bus_released;
   logic [15:0] cpu_addr;
   logic [1:0] release_mode;
   logic ph1, ph2, halt_req, cpu_addr_buf_en, data_to_cpu, refresh_active;
   logic row_drive_en, ram_sel, ram_cycle, ram_we, ram_rdbuf_en;
   logic peripheral_adapter_cs, adapter_control_input_one;
   logic [5:0] refresh_row;
   logic [3:0] eprom_sel;
   logic [7:0] eprom_word;
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   int last_rise = 0;
   int period = 0;
   logic prev_act = 1'b0;
   logic [15:0] dec_addr [10] = '{16'h0000, 16'h0fff, 16'h1000, 16'hf03f,
      16'hf040, 16'hf043, 16'hfbff, 16'hfc00, 16'hfdff, 16'hffff};

   ////////////////////////////////////////////////////////////////////
   // Design and processor model
   cbrd_top #(.REFRESH_CYCLES(REF_CYC), .RTC_TAP(TAP)) u_dut (
      .mclk(mclk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
      .cpu_rw(cpu_rw), .cpu_vma(cpu_vma), .bus_released(bus_released),
      .ph1(ph1), .ph2(ph2), .halt_req(halt_req),
      .cpu_addr_buf_en(cpu_addr_buf_en), .data_to_cpu(data_to_cpu),
      .refresh_active(refresh_active), .row_drive_en(row_drive_en),
      .refresh_row(refresh_row), .ram_sel(ram_sel), .ram_cycle(ram_cycle),
      .ram_we(ram_we), .ram_rdbuf_en(ram_rdbuf_en), .eprom_sel(eprom_sel),
      .eprom_word(eprom_word),
      .peripheral_adapter_cs(peripheral_adapter_cs),
      .adapter_control_input_one(adapter_control_input_one));
   cbrd_cpu_model u_cpu (.mclk(mclk), .sys_rst(sys_rst),
      .halt_req(halt_req), .release_mode(release_mode),
      .bus_released(bus_released));

   // 20 MHz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Spacing between refresh starts, in clocks
   always @(posedge mclk) begin
      cyc++;
      if (refresh_active === 1'b1 && prev_act !== 1'b1) begin
         period = cyc - last_rise;
         last_rise = cyc;
      end
      prev_act = refresh_active;
   end

   ////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check_val(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Inputs always move 2 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   task automatic bus(input logic [15:0] a, input logic r, input logic v);
      cpu_addr = a;
      cpu_rw = r;
      cpu_vma = v;
   endtask

   // Bounded wait; running out counts as a mismatch
   task automatic wait_refresh(input logic lvl);
      int n;
      for (n = 0; n < 3200 && refresh_active !== lvl; n++) step(1);
      if (n == 3200) fail_count++;
   endtask

   task automatic count_starts(input int n);
      repeat (n) begin
         wait_refresh(1'b1);
         wait_refresh(1'b0);
      end
   endtask

   task automatic complete_run;
      if (fail_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_phases;
      int n1 = 0;
      int n2 = 0;
      int nb = 0;
      repeat (30) begin
         step(1);
         n1 += int'(ph1 === 1'b1);
         n2 += int'(ph2 === 1'b1);
         nb += int'(ph1 !== 1'b0 && ph2 !== 1'b0);
      end
      check_val(16'(n1), 16'h000d);
      check_val(16'(n2), 16'h000f);
      check_val(16'(nb), 16'h0000);
   endtask

   // Whole decode table, reads and writes, with and without valid address
   task automatic t_decode;
      logic [15:0] a;
      logic r, v, ram, peripheral_adapter;
      logic [3:0] ep;
      wait_refresh(1'b1);
      wait_refresh(1'b0);
      for (int k = 0; k < 40; k++) begin
         a = dec_addr[k / 4];
         r = k[0];
         v = k[1];
         ram = v && a <= 16'h0fff;
         peripheral_adapter = v && a >= 16'hf040 && a <= 16'hf043;
         ep = (v && a >= 16'hfc00) ? 4'h1 << a[9:8] : 4'h0;
         bus(a, r, v);
         step(1);
         check_val(16'(ram_sel), 16'(ram));
         check_val(16'(ram_cycle), 16'(ram));
         check_val(16'(ram_rdbuf_en), 16'(ram && r));
         check_val(16'(data_to_cpu), 16'(r));
         check_val(16'(eprom_sel), 16'(ep));
         check_val(16'(eprom_word), 16'(a[7:0]));
         check_val(16'(peripheral_adapter_cs), 16'(peripheral_adapter));
      end
   endtask

   // Held write then held read; only the write may strobe
   task automatic t_write;
      int rise = -1;
      int we_at = -1;
      int we_rd = 0;
      bus(16'h0100, 1'b0, 1'b1);
      for (int i = 0; i < 40; i++) begin
         step(1);
         if (ram_cycle === 1'b1 && rise < 0) rise = i;
         if (ram_we === 1'b1 && we_at < 0) we_at = i;
      end
      check_val(16'(we_at >= 0), 16'h0001);
      check_val(16'(we_at - rise >= 4), 16'h0001);
      check_val(16'(ram_rdbuf_en), 16'h0000);
      bus(16'h0100, 1'b1, 1'b1);
      repeat (40) begin
         step(1);
         we_rd += int'(ram_we !== 1'b0);
      end
      check_val(16'(we_rd), 16'h0000);
      check_val(16'(ram_rdbuf_en), 16'h0001);
      bus(16'h0000, 1'b1, 1'b0);
   endtask

   // One refresh pass with the processor quick, slow or hung
   task automatic t_refresh(input logic [1:0] mode);
      int rows = 1;
      int last, gap;
      logic prev_rel;
      release_mode = mode;
      wait_refresh(1'b1);
      step(1);
      check_val(16'(period), 16'(REF_CYC));
      check_val(16'(halt_req), 16'h0001);
      check_val(16'(row_drive_en), 16'h0001);
      check_val(16'(ram_cycle), 16'h0001);
      check_val(16'(refresh_row), 16'h0000);
      gap = 0;
      prev_rel = bus_released;
      for (int n = 0; n < 3000 && refresh_active === 1'b1; n++) begin
         last = refresh_row;
         step(1);
         gap++;
         if (prev_rel === 1'b1) begin
            check_val(16'(cpu_addr_buf_en), 16'h0);
         end
         prev_rel = bus_released;
         if (refresh_active === 1'b1 && refresh_row !== 6'(last)) begin
            check_val(16'(refresh_row), 16'(last + 1));
            if (rows > 1) check_val(16'(gap), 16'h001e);
            rows++;
            gap = 0;
         end
      end
      check_val(16'(rows), 16'h0040);
      check_val(16'(halt_req), 16'h0000);
      check_val(16'(refresh_row), 16'h0000);
   endtask

   // Divider: cleared by reset and F044; adapter port A read clears the interrupt
   task automatic t_rtc;
      release_mode = 2'h0;
      sys_rst = 1'b1;
      step(2);
      sys_rst = 1'b0;
      count_starts(3);
      check_val(16'(adapter_control_input_one), 16'h0);
      count_starts(1);
      check_val(16'(adapter_control_input_one), 16'h1);
      bus(16'hf040, 1'b1, 1'b1);
      step(1);
      bus(16'h0000, 1'b1, 1'b0);
      step(1);
      check_val(16'(adapter_control_input_one), 16'h0);
      count_starts(2);
      bus(16'hf044, 1'b1, 1'b1);
      step(1);
      bus(16'h0000, 1'b1, 1'b0);
      count_starts(3);
      check_val(16'(adapter_control_input_one), 16'h0);
      count_starts(1);
      check_val(16'(adapter_control_input_one), 16'h1);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      release_mode = 2'h0;
      bus(16'h0000, 1'b1, 1'b0);
      step(4);
      check_val({ph1, ph2, halt_req, refresh_active, ram_sel,
         ram_cycle, ram_we, ram_rdbuf_en, peripheral_adapter_cs,
         adapter_control_input_one, refresh_row}, 16'h0000);
      check_val({eprom_sel, eprom_word, 2'h0, cpu_addr_buf_en,
         data_to_cpu}, 16'h0003);
      step(4);
      sys_rst = 1'b0;
      t_phases();
      t_decode();
      t_write();
      for (int m = 0; m < 3; m++) t_refresh(2'(m));
      t_rtc();
      complete_run();
   end

   // Watchdog sized well past the longest expected run
   initial begin
      repeat (90000) @(posedge mclk);
      fail_count++;
      complete_run();
   end
endmodule // tb_cpu_board_refresh_decode
`default_nettype wire
